// File: hw/dcfc_top.v
`timescale 1ns/1ns
`include "dcfc_defs.vh"

module dcfc_top (
  input  wire                    clk,
  input  wire                    reset,
  input  wire                    wclk,
  input  wire                    wr_en,
  input  wire [`DCFC_WORD_W-1:0] wr_data,
  input  wire                    rclk,
  input  wire                    rd_en,
  input  wire [2:0]              width_code,
  input  wire [3:0]              depth_sel,
  input  wire                    out_ready,
  output reg                     out_valid,
  output reg  [`DCFC_WORD_W-1:0] out_data,
  output reg                     empty,
  output reg                     full
);
  // ========================================================================
  // input synchronisers
  // every link and geometry input is caught by two flops; a third copy holds the
  // sample before a clock edge was seen, so data that the writer changes
  // right after its edge is never taken
  localparam SW = 47;
  wire [SW-1:0] raw;
  reg  [SW-1:0] sync1;
  reg  [SW-1:0] sync2;
  reg  [SW-1:0] sync3;

  assign raw = {wclk, wr_en, wr_data, rclk, rd_en, width_code, depth_sel};

  // no reset here: the geometry must reach sync2 while reset is held,
  // and an idle-high link clock must not look like a fresh edge on release
  always @(posedge clk) begin
    sync1 <= raw;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  wire                    w_rise = sync2[46] & ~sync3[46];
  wire                    w_en   = sync3[45];
  wire [`DCFC_WORD_W-1:0] w_data = sync3[44:9];
  wire                    r_rise = sync2[8] & ~sync3[8];
  wire                    r_en   = sync3[7];

  // ========================================================================
  // geometry, caught while reset is held so it never moves under traffic
  reg [2:0] cfg_width;
  reg [3:0] cfg_depth;

  always @(posedge clk) begin
    if (reset) begin
      cfg_width <= sync2[6:4];
      cfg_depth <= sync2[3:0];
    end
  end

  reg [`DCFC_WORD_W-1:0] word_mask;
  reg [4:0]              wlog;
  reg [4:0]              dlog;

  always @* begin
    // reserved 11x falls back to the widest organisation
    case (cfg_width)
      `DCFC_W_1X4K:   begin word_mask = `DCFC_MASK_1;  wlog = 5'h00; end
      `DCFC_W_2X2K:   begin word_mask = `DCFC_MASK_2;  wlog = 5'h01; end
      `DCFC_W_4X1K:   begin word_mask = `DCFC_MASK_4;  wlog = 5'h02; end
      `DCFC_W_9X512:  begin word_mask = `DCFC_MASK_9;  wlog = 5'h03; end
      `DCFC_W_18X256: begin word_mask = `DCFC_MASK_18; wlog = 5'h04; end
      default:        begin word_mask = `DCFC_MASK_36; wlog = 5'h05; end
    endcase
    // highest set pin wins; no pin set means a single block
    casez (cfg_depth)
      4'b1???: dlog = `DCFC_DLOG_16;
      4'b01??: dlog = `DCFC_DLOG_8;
      4'b001?: dlog = `DCFC_DLOG_4;
      4'b0001: dlog = `DCFC_DLOG_2;
      default: dlog = `DCFC_DLOG_1;
    endcase
  end

  wire [4:0]             cap_log  = `DCFC_BLOCK_LOG - wlog + dlog;
  wire [`DCFC_PTR_W-1:0] cap_bit  = `DCFC_PTR_ONE << cap_log;
  wire [`DCFC_PTR_W-1:0] addr_msk = cap_bit - `DCFC_PTR_ONE;
  wire [`DCFC_PTR_W-1:0] wrap_msk = {addr_msk[`DCFC_PTR_W-2:0], 1'b1};

  // ========================================================================
  // pointers and the array
  // pointers count modulo twice the capacity, so the bit just above the
  // address is the extra msb
  reg  [`DCFC_WORD_W-1:0] mem [0:`DCFC_MEM_WORDS-1];
  reg  [`DCFC_PTR_W-1:0]  write_pointer;
  reg  [`DCFC_PTR_W-1:0]  read_pointer;
  reg  [`DCFC_PTR_W-1:0]  wp_rd1;
  reg  [`DCFC_PTR_W-1:0]  wp_rd2;
  reg  [`DCFC_PTR_W-1:0]  rp_wr1;
  reg  [`DCFC_PTR_W-1:0]  rp_wr2;
  wire                    st_in_ready;
  wire                    st_out_valid;
  wire [`DCFC_STAGE_W-1:0] st_out_data;

  wire [`DCFC_PTR_W-1:0] next_write_pointer =
    (write_pointer + `DCFC_PTR_ONE) & wrap_msk;
  wire [`DCFC_PTR_W-1:0] next_read_pointer =
    (read_pointer + `DCFC_PTR_ONE) & wrap_msk;

  wire [`DCFC_ADDR_W-1:0] w_addr = write_pointer[`DCFC_ADDR_W-1:0]
                                   & addr_msk[`DCFC_ADDR_W-1:0];
  wire [`DCFC_ADDR_W-1:0] r_addr = read_pointer[`DCFC_ADDR_W-1:0]
                                   & addr_msk[`DCFC_ADDR_W-1:0];

  // a read also waits for room in the staging buffer
  wire do_write = w_rise & w_en & ~full;
  wire do_read  = r_rise & r_en & ~empty & st_in_ready;
  // one mask on both ports keeps write and read words the same width
  wire [`DCFC_WORD_W-1:0] rd_word = mem[r_addr] & word_mask;

  always @(posedge clk) begin
    if (do_write) begin
      mem[w_addr] <= w_data & word_mask;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      write_pointer <= `DCFC_PTR_ZERO;
      read_pointer  <= `DCFC_PTR_ZERO;
      wp_rd1        <= `DCFC_PTR_ZERO;
      wp_rd2        <= `DCFC_PTR_ZERO;
      rp_wr1        <= `DCFC_PTR_ZERO;
      rp_wr2        <= `DCFC_PTR_ZERO;
    end else begin
      if (do_write) begin
        write_pointer <= next_write_pointer;
      end
      if (do_read) begin
        read_pointer <= next_read_pointer;
      end
      // both sides live on clk, so a binary pointer moves coherently;
      // the two stages still cost the documented flag latency
      if (r_rise) begin
        wp_rd1 <= write_pointer;
        wp_rd2 <= wp_rd1;
      end
      if (w_rise) begin
        rp_wr1 <= read_pointer;
        rp_wr2 <= rp_wr1;
      end
    end
  end

  // ========================================================================
  // flags, straight from flops so no decode hazard reaches the pins
  // each trails its own side's pointer by one clk, and the far pointer by two rises of its own link clock more
  always @(posedge clk) begin
    if (reset) begin
      empty <= 1'b1;
      full  <= 1'b0;
    end else begin
      empty <= (read_pointer == wp_rd2);
      full  <= ((write_pointer ^ rp_wr2) == cap_bit);
    end
  end

  // ========================================================================
  // staging buffer and read data register
  wire st_pop = st_out_valid & (~out_valid | out_ready);

  dcfc_stage #(
    .WIDTH (`DCFC_STAGE_W),
    .DEPTH (`DCFC_STAGE_D),
    .AW    (`DCFC_STAGE_AW)
  ) u_stage (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (do_read),
    .in_ready  (st_in_ready),
    .in_data   (rd_word),
    .out_valid (st_out_valid),
    .out_ready (~out_valid | out_ready),
    .out_data  (st_out_data)
  );

  always @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data  <= {`DCFC_WORD_W{1'b0}};
    end else if (~out_valid | out_ready) begin
      out_valid <= st_out_valid;
      if (st_pop) begin
        out_data <= st_out_data;
      end
    end
  end
endmodule // dcfc_top

// File: hw/dcfc_defs.vh
`ifndef DCFC_DEFS_VH
`define DCFC_DEFS_VH

// width codes
`define DCFC_W_1X4K     3'h0
`define DCFC_W_2X2K     3'h1
`define DCFC_W_4X1K     3'h2
`define DCFC_W_9X512    3'h3
`define DCFC_W_18X256   3'h4
`define DCFC_W_36X128   3'h5

// word masks per width code
`define DCFC_MASK_1     36'h000000001
`define DCFC_MASK_2     36'h000000003
`define DCFC_MASK_4     36'h00000000f
`define DCFC_MASK_9     36'h0000001ff
`define DCFC_MASK_18    36'h00003ffff
`define DCFC_MASK_36    36'hfffffffff

// sizes
`define DCFC_WORD_W     36
`define DCFC_ADDR_W     16
`define DCFC_PTR_W      17
`define DCFC_MEM_WORDS  65536
`define DCFC_BLOCK_LOG  5'h0c
`define DCFC_STAGE_W    36
`define DCFC_STAGE_D    16
`define DCFC_STAGE_AW   4

// depth factor as log2 of cascaded blocks
`define DCFC_DLOG_1     5'h00
`define DCFC_DLOG_2     5'h01
`define DCFC_DLOG_4     5'h02
`define DCFC_DLOG_8     5'h03
`define DCFC_DLOG_16    5'h04

`define DCFC_PTR_ZERO   17'h00000
`define DCFC_PTR_ONE    17'h00001

`endif

// File: hw/dcfc_stage.v
`timescale 1ns/1ns
// ==========================================================================
// staging buffer between the array read and the read data register
module dcfc_stage #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_idx;
  reg [AW-1:0]    rd_idx;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_idx <= {AW{1'b0}};
      rd_idx <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= rd_idx + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule // dcfc_stage

// File: verification/dcfc_checker.sv
`timescale 1ns/1ns
// ==========================================
// flag and read port checks
module dcfc_checker (
  input wire        clk,
  input wire        reset,
  input wire [2:0]  width_code,
  input wire        out_ready,
  input wire        out_valid,
  input wire [35:0] out_data,
  input wire        empty,
  input wire        full
);
  // reserved codes 11x read as full width
  wire [35:0] msk = width_code[2] ? (|width_code[1:0] ? 36'hfffffffff :
    36'h3ffff) : width_code[1] ? (width_code[0] ? 36'h1ff : 36'hf) :
    (width_code[0] ? 36'h3 : 36'h1);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_RST_FLAGS: assert property (disable iff (1'b0)
    reset |=> empty && !full && !out_valid) else $error("bad reset flags");
  AST_RST_DATA: assert property (disable iff (1'b0)
    reset |=> out_data == 36'h0) else $error("bad reset data");
  AST_NOT_BOTH: assert property (!(empty && full))
    else $error("empty and full together");
  AST_EMPTY_HOLD: assert property ($rose(empty) |=> empty[*2])
    else $error("empty pulse");
  AST_LEAVE_EMPTY: assert property ($fell(empty) |=> !empty[*2])
    else $error("empty glitch");
  AST_FULL_HOLD: assert property ($rose(full) |=> full[*2])
    else $error("full pulse");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("read word not held");
  AST_MASK: assert property (out_valid |-> (out_data & ~msk) == 36'h0)
    else $error("bits above width");
  cover property ($fell(empty));
  cover property ($rose(full));
  cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule // dcfc_checker
bind dcfc_top dcfc_checker u_chk (.clk(clk), .reset(reset),
  .width_code(width_code), .out_ready(out_ready), .out_valid(out_valid),
  .out_data(out_data), .empty(empty), .full(full));

// File: verification/dcfc_user.sv
`timescale 1ns/1ns
// ==========================================
// writer and reader logic on their own clocks
module dcfc_user (
  input  wire        clk,
  output reg         wclk,
  output reg         rclk,
  output reg         wr_en,
  output reg  [35:0] wr_data,
  output reg         rd_en
);
  initial begin
    wclk = 1'b0;
    rclk = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 36'h0;
  end
  // odd offsets keep both clocks out of phase with clk
  initial begin
    #7;
    forever #200 wclk = ~wclk;
  end
  initial begin
    #131;
    forever #200 rclk = ~rclk;
  end
  // request spans exactly one writer rise; data inverted once released
  task put(input [35:0] d);
    @(negedge wclk);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_data <= d;
    @(negedge wclk);
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask
  task get;
    @(negedge rclk);
    @(posedge clk);
    rd_en <= 1'b1;
    @(negedge rclk);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
endmodule // dcfc_user

// File: verification/dcfc_top_tb.sv
`timescale 1ns/1ns
module dcfc_top_tb;
  reg         clk;
  reg         reset;
  reg  [2:0]  width_code;
  reg  [3:0]  depth_sel;
  reg         out_ready;
  wire        wclk, rclk, wr_en, rd_en, out_valid, empty, full;
  wire [35:0] wr_data, out_data;
  integer     miscompares, n_checks, cyc, i, k;
  reg  [35:0] exp_q[$];
  reg  [35:0] msk;

  dcfc_user U (.clk(clk), .wclk(wclk), .rclk(rclk), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en));
  dcfc_top DUT (.clk(clk), .reset(reset), .wclk(wclk), .wr_en(wr_en),
    .wr_data(wr_data), .rclk(rclk), .rd_en(rd_en), .width_code(width_code),
    .depth_sel(depth_sel), .out_ready(out_ready), .out_valid(out_valid),
    .out_data(out_data), .empty(empty), .full(full));

  task check(input [35:0] s, input [35:0] e, input string nm);
    n_checks = n_checks + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task do_reset(input [2:0] w, input [3:0] d);
    @(posedge clk);
    reset <= 1'b1;
    width_code <= w;
    depth_sel <= d;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check(empty, 36'h1, "empty");
    check(full, 36'h0, "full");
    msk = (w > 4) ? 36'hfffffffff : (w == 4) ? 36'h3ffff :
      (w == 3) ? 36'h1ff : (36'h1 << (1 << w)) - 36'h1;
  endtask
  task wr(input [35:0] d);
    U.put(d);
    exp_q.push_back(d & msk);
  endtask
  // f selects full, otherwise empty; bounded wait then compare
  task wait_flag(input f, input v);
    #1;
    for (k = 0; k < 80 && (f ? full : empty) !== v; k = k + 1) begin
      @(posedge clk);
      #1;
    end
    check(f ? full : empty, v, f ? "full" : "empty");
  endtask

  // ==========================================
  // read side monitor and timeout
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end else if (!reset && out_valid === 1'b1 && out_ready) begin
      check(out_data, exp_q.pop_front(), "out_data");
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    width_code = 3'h0;
    depth_sel = 4'h0;
    out_ready = 1'b1;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    for (i = 0; i < 6; i = i + 1) begin
      do_reset(i[2:0], 4'h1 << (i % 4));
      wr(36'hfffffffff);
      wr(36'h5a5a5a5a5);
      wait_flag(1'b0, 1'b0);
      U.get;
      U.get;
      wait_flag(1'b0, 1'b1);
      repeat (8) @(posedge clk);
    end
    // consumer stalls while words queue in the staging buffer
    @(posedge clk) out_ready <= 1'b0;
    for (i = 0; i < 3; i = i + 1) wr(36'h111111111 * i);
    wait_flag(1'b0, 1'b0);
    for (i = 0; i < 3; i = i + 1) U.get;
    repeat (20) @(posedge clk);
    check(out_valid, 36'h1, "out_valid");
    @(posedge clk) out_ready <= 1'b1;
    // let the queued words drain before reset clears them
    repeat (8) @(posedge clk);
    do_reset(3'h5, 4'h1);
    for (i = 0; i < 256; i = i + 1) wr(36'(i));
    wait_flag(1'b1, 1'b1);
    U.put(36'h123456789);
    U.get;
    wait_flag(1'b1, 1'b0);
    for (i = 0; i < 255; i = i + 1) U.get;
    wait_flag(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    wrap_up;
  end
endmodule // dcfc_top_tb
